// ==== design/ett_trigger_top.v ====
`timescale 1ns/100ps
`include "ett_consts.vh"

module ett_trigger_top #(
  parameter CNT_W       = `ETT_CNT_W,
  parameter TRACE_DEPTH = `ETT_TRACE_DEPTH,
  parameter TRACE_AW    = `ETT_TRACE_AW
) (
  input  wire                        clock,
  input  wire                        rst_n,
  input  wire [`ETT_ADDR_W-1:0]      exec_addr,
  input  wire                        exec_valid,
  input  wire [`ETT_ADDR_W-1:0]      bus_addr,
  input  wire [`ETT_DATA_W-1:0]      bus_data,
  input  wire [`ETT_STAT_W-1:0]      bus_status,
  input  wire [`ETT_CLIP_W-1:0]      clips,
  input  wire                        bus_cycle,
  input  wire                        global_trigger_in,
  input  wire                        global_trace_in,
  input  wire                        emulation_start,
  input  wire                        arm_request,
  input  wire                        disarm_request,
  input  wire                        enable_write,
  input  wire                        enable_break_value,
  input  wire                        enable_trace_value,
  input  wire [`ETT_ADDR_W-1:0]      exec_match_pattern,
  input  wire [`ETT_ADDR_W-1:0]      exec_match_care,
  input  wire [`ETT_BUS_WR_W-1:0]    bus_match_pattern,
  input  wire [`ETT_BUS_WR_W-1:0]    bus_match_care,
  input  wire [`ETT_PROG_CW-1:0]     exec_trigger_program_cond,
  input  wire [`ETT_PROG_AW-1:0]     exec_trigger_program_if,
  input  wire [`ETT_PROG_AW-1:0]     exec_trigger_program_else,
  input  wire [`ETT_PROG_CW-1:0]     bus_trigger_program_cond,
  input  wire [`ETT_PROG_AW-1:0]     bus_trigger_program_if,
  input  wire [`ETT_PROG_AW-1:0]     bus_trigger_program_else,
  input  wire [`ETT_SW-1:0]          exec_start_state,
  input  wire [`ETT_SW-1:0]          bus_start_state,
  input  wire [CNT_W-1:0]            exec_count_limit,
  input  wire [CNT_W-1:0]            bus_count_limit,
  input  wire [TRACE_AW-1:0]         trace_read_addr,
  output reg                         emulation_running,
  output reg                         emulation_halt,
  output reg                         trace_collecting,
  output reg                         trace_buffer_full,
  output reg  [TRACE_AW-1:0]         trace_write_pointer,
  output reg  [`ETT_FRAME_W-1:0]     trace_read_data,
  output reg                         global_trigger_out,
  output reg                         global_trace_request_out,
  output reg                         global_armed,
  output reg                         global_break_input_enable,
  output reg                         global_trace_input_enable,
  output wire                        exec_machine_link_flag,
  output wire                        bus_machine_link_flag,
  output wire [`ETT_SW-1:0]          exec_state,
  output wire [`ETT_SW-1:0]          bus_state,
  output wire [CNT_W-1:0]            exec_count,
  output wire [CNT_W-1:0]            bus_count,
  output wire                        exec_counter_terminal_match,
  output wire                        bus_counter_terminal_match
);

  // ---------------------------------------------------------------
  // States and helpers
  // ---------------------------------------------------------------
  localparam [3:0] ST_S0 = 4'h1;
  localparam [3:0] ST_S1 = 4'h2;
  localparam [3:0] ST_S2 = 4'h4;
  localparam [3:0] ST_S3 = 4'h8;
  localparam SYNC_W = 2 * `ETT_ADDR_W + `ETT_DATA_W + `ETT_STAT_W + `ETT_CLIP_W + 4;

  function [`ETT_SW-1:0] ett_state_index;
    input [3:0] onehot;
    begin
      case (onehot)
        ST_S0:   ett_state_index = 2'h0;
        ST_S1:   ett_state_index = 2'h1;
        ST_S2:   ett_state_index = 2'h2;
        ST_S3:   ett_state_index = 2'h3;
        default: ett_state_index = 2'h0;
      endcase
    end
  endfunction

  function [3:0] ett_state_decode;
    input [`ETT_SW-1:0] index;
    begin
      case (index)
        2'h0:    ett_state_decode = ST_S0;
        2'h1:    ett_state_decode = ST_S1;
        2'h2:    ett_state_decode = ST_S2;
        2'h3:    ett_state_decode = ST_S3;
        default: ett_state_decode = ST_S0;
      endcase
    end
  endfunction

  // All used terms true after optional inversion; no terms means always
  function ett_clause_true;
    input [`ETT_TERMS-1:0] use_term;
    input [`ETT_TERMS-1:0] invert;
    input [`ETT_TERMS-1:0] terms;
    begin
      ett_clause_true = &(~use_term | (terms ^ invert));
    end
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  reg  [SYNC_W-1:0] sync_first;
  reg  [SYNC_W-1:0] sync_second;
  reg               exec_valid_prev;
  reg               bus_cycle_prev;
  wire [SYNC_W-1:0] pins_raw;

  assign pins_raw = {global_trace_in, global_trigger_in, bus_cycle, exec_valid,
                     bus_status, clips, bus_data, bus_addr, exec_addr};

  wire [`ETT_ADDR_W-1:0] s_exec_addr;
  wire [`ETT_ADDR_W-1:0] s_bus_addr;
  wire [`ETT_DATA_W-1:0] s_bus_data;
  wire [`ETT_CLIP_W-1:0] s_clips;
  wire [`ETT_STAT_W-1:0] s_bus_status;
  wire                   s_exec_valid;
  wire                   s_bus_cycle;
  wire                   s_ext_trigger;
  wire                   s_ext_trace;

  assign {s_ext_trace, s_ext_trigger, s_bus_cycle, s_exec_valid,
          s_bus_status, s_clips, s_bus_data, s_bus_addr, s_exec_addr} = sync_second;

  always @(posedge clock) begin
    if (!rst_n) begin
      sync_first      <= {SYNC_W{1'b0}};
      sync_second     <= {SYNC_W{1'b0}};
      exec_valid_prev <= 1'b0;
      bus_cycle_prev  <= 1'b0;
    end else begin
      sync_first      <= pins_raw;
      sync_second     <= sync_first;
      exec_valid_prev <= s_exec_valid;
      bus_cycle_prev  <= s_bus_cycle;
    end
  end

  // ---------------------------------------------------------------
  // Word recognizers
  // ---------------------------------------------------------------
  wire [`ETT_MACHINES-1:0] word_match;
  wire [`ETT_MACHINES-1:0] event_strobe;

  ett_word_recognizer #(
    .WIDTH (`ETT_ADDR_W)
  ) u_exec_recognizer (
    .observed (s_exec_addr),
    .pattern  (exec_match_pattern),
    .care     (exec_match_care),
    .match    (word_match[0])
  );

  ett_word_recognizer #(
    .WIDTH (`ETT_BUS_WR_W)
  ) u_bus_recognizer (
    .observed ({s_bus_status, s_clips, s_bus_data, s_bus_addr}),
    .pattern  (bus_match_pattern),
    .care     (bus_match_care),
    .match    (word_match[1])
  );

  assign event_strobe = {s_bus_cycle & ~bus_cycle_prev, s_exec_valid & ~exec_valid_prev};

  // ---------------------------------------------------------------
  // Trigger machines
  // ---------------------------------------------------------------
  wire [2*`ETT_PROG_CW-1:0]         prog_cond;
  wire [2*`ETT_PROG_AW-1:0]         prog_if;
  wire [2*`ETT_PROG_AW-1:0]         prog_else;
  wire [2*`ETT_SW-1:0]              start_sel;
  wire [2*CNT_W-1:0]                limits;
  wire [2*CNT_W-1:0]                counts;
  wire [`ETT_MACHINES-1:0]          terminal;
  wire [`ETT_MACHINES-1:0]          link;
  wire [`ETT_MACHINES-1:0]          fires;
  wire [2*`ETT_SW-1:0]              state_index;
  wire [2*`ETT_ACT_W-1:0]           acts;

  assign prog_cond = {bus_trigger_program_cond, exec_trigger_program_cond};
  assign prog_if   = {bus_trigger_program_if, exec_trigger_program_if};
  assign prog_else = {bus_trigger_program_else, exec_trigger_program_else};
  assign start_sel = {bus_start_state, exec_start_state};
  assign limits    = {bus_count_limit, exec_count_limit};

  genvar m;
  generate
    for (m = 0; m < `ETT_MACHINES; m = m + 1) begin : g_machine
      localparam [`ETT_ACT_W-1:0] ACT_MASK = (m == 1) ? {`ETT_ACT_W{1'b1}} : `ETT_EXEC_ACT_MASK;
      reg  [3:0]              state;
      wire [`ETT_SW-1:0]      idx;
      wire [`ETT_COND_W-1:0]  cond;
      wire [`ETT_TERMS-1:0]   terms;
      wire                    hit;
      wire [`ETT_ACT_W-1:0]   act;
      wire                    fire;

      assign idx   = ett_state_index(state);
      assign cond  = prog_cond[m*`ETT_PROG_CW + idx*`ETT_COND_W +: `ETT_COND_W];
      assign terms = {(m == 1) ? trace_buffer_full : 1'b0,
                      link[1-m],
                      terminal[m],
                      word_match[m]};
      assign hit   = ett_clause_true(cond[`ETT_COND_USE_LO +: `ETT_TERMS],
                                     cond[`ETT_COND_INV_LO +: `ETT_TERMS], terms);
      assign act   = (hit ? prog_if[m*`ETT_PROG_AW + idx*`ETT_ACT_W +: `ETT_ACT_W]
                          : prog_else[m*`ETT_PROG_AW + idx*`ETT_ACT_W +: `ETT_ACT_W])
                     & ACT_MASK;
      assign fire  = emulation_running & event_strobe[m];

      always @(posedge clock) begin
        if (!rst_n) begin
          state <= ST_S0;
        end else if (emulation_start) begin
          state <= ett_state_decode(start_sel[m*`ETT_SW +: `ETT_SW]);
        end else if (fire && act[`ETT_A_GOTO]) begin
          state <= ett_state_decode(act[`ETT_A_DEST_LO +: `ETT_SW]);
        end
      end

      ett_event_counter #(
        .WIDTH (CNT_W)
      ) u_counter (
        .clock     (clock),
        .rst_n     (rst_n),
        .clear     (emulation_start),
        .increment (fire & act[`ETT_A_COUNT]),
        .limit     (limits[m*CNT_W +: CNT_W]),
        .count     (counts[m*CNT_W +: CNT_W]),
        .terminal  (terminal[m])
      );

      assign link[m]                          = (state == ST_S3);
      assign fires[m]                         = fire;
      assign state_index[m*`ETT_SW +: `ETT_SW] = idx;
      assign acts[m*`ETT_ACT_W +: `ETT_ACT_W]  = act;
    end
  endgenerate

  // ---------------------------------------------------------------
  // Arm, trigger and break
  // ---------------------------------------------------------------
  wire [`ETT_ACT_W-1:0] exec_act;
  wire [`ETT_ACT_W-1:0] bus_act;
  wire                  local_trigger;
  wire                  system_break;
  wire                  machine_break;
  wire                  next_armed;

  assign exec_act      = acts[0 +: `ETT_ACT_W];
  assign bus_act       = acts[`ETT_ACT_W +: `ETT_ACT_W];
  assign local_trigger = fires[1] & bus_act[`ETT_A_TRIG];
  assign machine_break = (fires[0] & exec_act[`ETT_A_BREAK])
                       | (fires[1] & bus_act[`ETT_A_BREAK]);
  assign system_break  = global_armed
                       & (local_trigger | (global_break_input_enable & s_ext_trigger));
  assign next_armed    = (arm_request | (fires[1] & bus_act[`ETT_A_ARM])) ? 1'b1 :
                         (disarm_request | (fires[1] & bus_act[`ETT_A_DISARM])) ? 1'b0 :
                         global_armed;

  always @(posedge clock) begin
    if (!rst_n) begin
      global_armed              <= 1'b0;
      global_trigger_out        <= 1'b0;
      global_break_input_enable <= 1'b1;
      global_trace_input_enable <= 1'b1;
      emulation_running         <= 1'b0;
      emulation_halt            <= 1'b0;
    end else begin
      global_armed       <= next_armed;
      global_trigger_out <= local_trigger;
      if (enable_write) begin
        global_break_input_enable <= enable_break_value;
        global_trace_input_enable <= enable_trace_value;
      end
      if (emulation_start) begin
        emulation_running <= 1'b1;
        emulation_halt    <= 1'b0;
      end else if (emulation_running && (machine_break || system_break)) begin
        emulation_running <= 1'b0;
        emulation_halt    <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Trace collection
  // ---------------------------------------------------------------
  wire next_global_trace;
  wire next_trace;

  assign next_global_trace = emulation_running & bus_act[`ETT_A_GTRACE];
  assign next_trace = emulation_running
                    & (exec_act[`ETT_A_TRACE] | bus_act[`ETT_A_TRACE]
                       | (global_trace_input_enable & (s_ext_trace | next_global_trace)));

  always @(posedge clock) begin
    if (!rst_n) begin
      global_trace_request_out <= 1'b0;
      trace_collecting         <= 1'b0;
    end else begin
      global_trace_request_out <= next_global_trace;
      trace_collecting         <= next_trace;
    end
  end

  // ---------------------------------------------------------------
  // Trace buffer
  // ---------------------------------------------------------------
  reg  [`ETT_FRAME_W-1:0] trace_mem [0:TRACE_DEPTH-1];
  wire                    trace_write;
  wire [`ETT_FRAME_W-1:0] trace_frame;

  assign trace_write = trace_collecting & emulation_running & (|event_strobe);
  assign trace_frame = {s_bus_data, s_bus_addr, s_exec_addr};

  always @(posedge clock) begin
    if (trace_write) begin
      trace_mem[trace_write_pointer] <= trace_frame;
    end
    trace_read_data <= trace_mem[trace_read_addr];
  end

  always @(posedge clock) begin
    if (!rst_n) begin
      trace_write_pointer <= {TRACE_AW{1'b0}};
      trace_buffer_full   <= 1'b0;
    end else if (emulation_start) begin
      trace_write_pointer <= {TRACE_AW{1'b0}};
      trace_buffer_full   <= 1'b0;
    end else if (trace_write) begin
      trace_write_pointer <= trace_write_pointer + {{(TRACE_AW-1){1'b0}}, 1'b1};
      if (trace_write_pointer == TRACE_DEPTH[TRACE_AW-1:0] - {{(TRACE_AW-1){1'b0}}, 1'b1}) begin
        trace_buffer_full <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------
  assign exec_machine_link_flag      = link[0];
  assign bus_machine_link_flag       = link[1];
  assign exec_state                  = state_index[0 +: `ETT_SW];
  assign bus_state                   = state_index[`ETT_SW +: `ETT_SW];
  assign exec_count                  = counts[0 +: CNT_W];
  assign bus_count                   = counts[CNT_W +: CNT_W];
  assign exec_counter_terminal_match = terminal[0];
  assign bus_counter_terminal_match  = terminal[1];

endmodule // ett_trigger_top

// ==== design/ett_consts.vh ====
`ifndef ETT_CONSTS_VH
`define ETT_CONSTS_VH
// ---------------------------------------------------------------
// Widths of the observed lines, counters and trace buffer
// ---------------------------------------------------------------
`define ETT_ADDR_W        24
`define ETT_DATA_W        16
`define ETT_STAT_W        4
`define ETT_CLIP_W        8
`define ETT_BUS_WR_W      52
`define ETT_CNT_W         17
`define ETT_TRACE_DEPTH   1024
`define ETT_TRACE_AW      10
`define ETT_FRAME_W       64
// ---------------------------------------------------------------
// Machine states and program layout
// ---------------------------------------------------------------
`define ETT_MACHINES      2
`define ETT_SW            2
`define ETT_S0_INDEX      2'h0
`define ETT_COND_W        8
`define ETT_PROG_CW       32
`define ETT_PROG_AW       40
`define ETT_TERMS         4
`define ETT_COND_USE_LO   0
`define ETT_COND_INV_LO   4
`define ETT_T_WORD        0
`define ETT_T_TERMINAL    1
`define ETT_T_LINK        2
`define ETT_T_FULL        3
// ---------------------------------------------------------------
// Action word fields
// ---------------------------------------------------------------
`define ETT_ACT_W         10
`define ETT_A_GOTO        0
`define ETT_A_DEST_LO     1
`define ETT_A_COUNT       3
`define ETT_A_BREAK       4
`define ETT_A_TRACE       5
`define ETT_A_ARM         6
`define ETT_A_DISARM      7
`define ETT_A_TRIG        8
`define ETT_A_GTRACE      9
`define ETT_EXEC_ACT_MASK 10'h03F
`endif

// ==== design/ett_word_recognizer.v ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Masked compare of observed lines
// ---------------------------------------------------------------
module ett_word_recognizer #(
  parameter WIDTH = 24
) (
  input  wire [WIDTH-1:0] observed,
  input  wire [WIDTH-1:0] pattern,
  input  wire [WIDTH-1:0] care,
  output wire             match
);

  assign match = (((observed ^ pattern) & care) == {WIDTH{1'b0}});

endmodule // ett_word_recognizer

// ==== design/ett_event_counter.v ====
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Event counter with terminal compare
// ---------------------------------------------------------------
module ett_event_counter #(
  parameter WIDTH = 17
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             clear,
  input  wire             increment,
  input  wire [WIDTH-1:0] limit,
  output reg  [WIDTH-1:0] count,
  output wire             terminal
);

  always @(posedge clock) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
    end else if (clear) begin
      count <= {WIDTH{1'b0}};
    end else if (increment) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  assign terminal = (count == limit);

endmodule // ett_event_counter

// ==== tb/ett_trigger_properties.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checks of the trigger machines
// ------------------------------------------------------------
module ett_trigger_properties #(
  parameter CNT_W = 17
) (
  input wire             clock,
  input wire             rst_n,
  input wire             emulation_start,
  input wire             arm_request,
  input wire             global_trigger_in,
  input wire [1:0]       exec_start_state,
  input wire [CNT_W-1:0] exec_count_limit,
  input wire             emulation_running,
  input wire             emulation_halt,
  input wire             trace_collecting,
  input wire             trace_buffer_full,
  input wire             global_trigger_out,
  input wire             global_armed,
  input wire             global_break_input_enable,
  input wire             global_trace_input_enable,
  input wire             exec_machine_link_flag,
  input wire             bus_machine_link_flag,
  input wire [1:0]       exec_state,
  input wire [1:0]       bus_state,
  input wire [CNT_W-1:0] exec_count,
  input wire             exec_counter_terminal_match
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_armed_trig;
    emulation_running && global_armed && global_break_input_enable && global_trigger_in;
  endsequence
  property p_ext_break; s_armed_trig [*4] |-> ##[0:2] emulation_halt; endproperty
  a_ext_break: assert property (p_ext_break) else $error("armed trigger did not halt");
  property p_en_reset; $rose(rst_n) |-> global_break_input_enable && global_trace_input_enable; endproperty
  a_en_reset: assert property (p_en_reset) else $error("input enables not set");
  property p_arm; arm_request |=> global_armed; endproperty
  a_arm: assert property (p_arm) else $error("arm not taken");
  property p_start; emulation_start |=> exec_state == $past(exec_start_state) && exec_count == '0; endproperty
  a_start: assert property (p_start) else $error("start state or count wrong");
  property p_link_x; exec_machine_link_flag == (exec_state == 2'h3); endproperty
  a_link_x: assert property (p_link_x) else $error("exec link flag wrong");
  property p_link_b; bus_machine_link_flag == (bus_state == 2'h3); endproperty
  a_link_b: assert property (p_link_b) else $error("bus link flag wrong");
  property p_term; exec_counter_terminal_match == (exec_count == exec_count_limit); endproperty
  a_term: assert property (p_term) else $error("terminal match wrong");
  property p_full_hold; trace_buffer_full && !emulation_start |=> trace_buffer_full; endproperty
  a_full_hold: assert property (p_full_hold) else $error("full dropped");
  property p_halt_run; $rose(emulation_halt) |-> $past(emulation_running); endproperty
  a_halt_run: assert property (p_halt_run) else $error("halt while stopped");
  property p_trace_run; !emulation_running |=> !trace_collecting; endproperty
  a_trace_run: assert property (p_trace_run) else $error("trace while stopped");
  property p_trig_pulse; global_trigger_out |=> !global_trigger_out; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger not a pulse");
endmodule // ett_trigger_properties

bind ett_trigger_top ett_trigger_properties #(.CNT_W(CNT_W)) ett_trigger_properties_i (.*);

// ==== tb/ett_target_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Target execution and bus pins
// ------------------------------------------------------------
module ett_target_model (
  input  wire        clock,
  output reg  [23:0] exec_addr,
  output reg         exec_valid,
  output reg  [23:0] bus_addr,
  output reg  [15:0] bus_data,
  output reg         bus_cycle
);
  initial begin
    {exec_valid, bus_cycle} = 2'b00;
    {exec_addr, bus_addr, bus_data} = 64'h0;
  end
  // One event; released lines show the inverse
  task automatic cycle_event(input logic on_bus, input logic [23:0] a);
    @(posedge clock);
    {exec_addr, bus_addr, bus_data} <= {a, a, a[15:0]};
    {exec_valid, bus_cycle} <= {!on_bus, on_bus};
    repeat (2) @(posedge clock);
    {exec_valid, bus_cycle} <= 2'b00;
    {exec_addr, bus_addr, bus_data} <= ~{a, a, a[15:0]};
    repeat (5) @(posedge clock);
    #1;
  endtask
endmodule // ett_target_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  logic        clock, rst_n, exec_valid, bus_cycle, global_trigger_in, global_trace_in, emulation_start;
  logic        arm_request, disarm_request, enable_write, enable_break_value, enable_trace_value;
  logic        emulation_running, emulation_halt, trace_collecting, trace_buffer_full, global_trigger_out;
  logic        global_trace_request_out, global_armed, global_break_input_enable, global_trace_input_enable;
  logic        exec_machine_link_flag, bus_machine_link_flag, exec_counter_terminal_match;
  logic        bus_counter_terminal_match;
  logic [23:0] exec_addr, bus_addr, exec_match_pattern, exec_match_care;
  logic [15:0] bus_data;
  logic [3:0]  bus_status;
  logic [7:0]  clips;
  logic [51:0] bus_match_pattern, bus_match_care;
  logic [31:0] exec_trigger_program_cond, bus_trigger_program_cond;
  logic [39:0] exec_trigger_program_if, exec_trigger_program_else, bus_trigger_program_if, bus_trigger_program_else;
  logic [1:0]  exec_start_state, bus_start_state, exec_state, bus_state;
  logic [16:0] exec_count_limit, bus_count_limit, exec_count, bus_count;
  logic [9:0]  trace_read_addr, trace_write_pointer;
  logic [63:0] trace_read_data;
  int          failures, checked, trig_seen;

  ett_trigger_top ett_trigger_top_i (.*);
  ett_target_model ett_target_model_i (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (global_trigger_out === 1'b1) trig_seen++;
  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse(input int k, input logic [1:0] en);
    @(posedge clock);
    {emulation_start, arm_request, enable_write, disarm_request} <= {k == 0, k == 1, k == 2, k == 3};
    {enable_break_value, enable_trace_value} <= en;
    @(posedge clock);
    {emulation_start, arm_request, enable_write, disarm_request} <= 4'h0;
    idle(1);
  endtask
  task automatic ev(input logic on_bus, input logic [23:0] a);
    ett_target_model_i.cycle_event(on_bus, a);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12000) @(posedge clock);
    failures++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    {emulation_start, arm_request, enable_write, disarm_request} = 4'h0;
    {global_trigger_in, global_trace_in, enable_break_value, enable_trace_value} = 4'h0;
    {bus_status, clips, trace_read_addr} = {4'h3, 8'h5A, 10'h000};
    {exec_match_pattern, exec_match_care} = 48'h012345FFFFFF;
    {bus_match_pattern, bus_match_care} = {52'h35A00000ABCDE, 52'hFFF0000FFFFFF};
    {exec_start_state, bus_start_state} = 4'h0;
    {exec_count_limit, bus_count_limit} = {17'h00001, 17'h10000};
    {exec_trigger_program_cond, bus_trigger_program_cond} = 64'h0000000100000000;
    exec_trigger_program_if = {10'h010, 20'h00000, 10'h00F};
    {exec_trigger_program_else, bus_trigger_program_if, bus_trigger_program_else} = 120'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    idle(1);
    cmp("break enable", 1, global_break_input_enable);
    cmp("trace enable", 1, global_trace_input_enable);
    pulse(0, 2'b11);
    cmp("exec state", 0, exec_state);
    ev(0, 24'h000111);
    cmp("exec state", 0, exec_state);
    ev(0, 24'h012345);
    cmp("exec state", 3, exec_state);
    cmp("exec link", 1, exec_machine_link_flag);
    cmp("exec count", 1, exec_count);
    cmp("terminal", 1, exec_counter_terminal_match);
    cmp("halt", 0, emulation_halt);
    ev(0, 24'h000111);
    cmp("halt", 1, emulation_halt);
    cmp("running", 0, emulation_running);
    $display("test done: execution machine");
    @(posedge clock);
    {exec_trigger_program_cond, exec_trigger_program_if} <= 72'h0;
    bus_trigger_program_cond <= 32'h00000101;
    bus_trigger_program_if <= {20'h00000, 10'h100, 10'h10B};
    bus_trigger_program_else <= {20'h00000, 10'h040, 10'h000};
    pulse(0, 2'b11);
    ev(1, 24'h0ABCDE);
    cmp("bus state", 1, bus_state);
    cmp("bus count", 1, bus_count);
    cmp("bus terminal", 0, bus_counter_terminal_match);
    cmp("triggers", 1, trig_seen);
    cmp("halt", 0, emulation_halt);
    ev(1, 24'h000111);
    cmp("armed", 1, global_armed);
    ev(1, 24'h000111);
    cmp("armed", 1, global_armed);
    ev(1, 24'h0ABCDE);
    cmp("triggers", 2, trig_seen);
    cmp("halt", 1, emulation_halt);
    pulse(3, 2'b11);
    cmp("armed", 0, global_armed);
    pulse(1, 2'b11);
    cmp("armed", 1, global_armed);
    $display("test done: bus machine");
    @(posedge clock);
    {bus_trigger_program_cond, bus_trigger_program_if, bus_trigger_program_else} <= 112'h0;
    {global_trigger_in, global_trace_in} <= 2'b11;
    pulse(2, 2'b00);
    pulse(0, 2'b00);
    idle(8);
    cmp("halt", 0, emulation_halt);
    cmp("tracing", 0, trace_collecting);
    pulse(2, 2'b01);
    idle(4);
    cmp("tracing", 1, trace_collecting);
    pulse(2, 2'b11);
    idle(4);
    cmp("halt", 1, emulation_halt);
    $display("test done: external inputs");
    @(posedge clock);
    global_trigger_in <= 1'b0;
    bus_trigger_program_cond <= 32'h00000008;
    bus_trigger_program_if <= 40'h0000000010;
    bus_trigger_program_else <= 40'h0000000200;
    idle(4);
    pulse(0, 2'b11);
    for (int i = 0; i < 1023; i++) ev(1, 24'h000111);
    cmp("pointer", 10'h3FF, trace_write_pointer);
    cmp("full", 0, trace_buffer_full);
    cmp("global trace", 1, global_trace_request_out);
    ev(1, 24'h000111);
    cmp("full", 1, trace_buffer_full);
    cmp("pointer", 0, trace_write_pointer);
    cmp("halt", 0, emulation_halt);
    ev(1, 24'h000111);
    cmp("halt", 1, emulation_halt);
    @(posedge clock);
    trace_read_addr <= 10'h005;
    idle(2);
    cmp("trace frame", 64'h0111000111000111, trace_read_data);
    $display("test done: trace buffer");
    complete_run();
  end
endmodule // tb_top
